// ### mdc_defines.svh
// offsets, write masks, select codes, reset values and timing counts of the motor configuration bank
`ifndef MDC_DEFINES_SVH
`define MDC_DEFINES_SVH
`define MDC_ADDR_CFG_A 8'h90
`define MDC_ADDR_CFG_B 8'h91
`define MDC_CFG_A_RESET 16'h0000
`define MDC_CFG_B_RESET 16'h0000
`define MDC_CFG_A_WMASK 16'hFFFF
`define MDC_CFG_B_WMASK 16'h7FFF
`define MDC_SS_OFF 2'h0
`define MDC_SS_5 2'h1
`define MDC_SS_10 2'h2
`define MDC_SS_15 2'h3
`define MDC_DITHER_5 4'h5
`define MDC_DITHER_10 4'hA
`define MDC_DITHER_15 4'hF
`define MDC_OL_BOTH 2'h0
`define MDC_OL_CLOSED_ONLY 2'h1
`define MDC_OL_FIRST_OPEN 2'h2
`define MDC_CLK_FREQ_KHZ 10000
`define MDC_OL_DELAY_MS 280
`endif

// ### mdc_pkg.sv
// types shared by the motor configuration bank
package mdc_pkg;
	// first configuration register layout, msb first
	typedef struct packed {
		logic [1:0] spread_spectrum_sel;
		logic [1:0] tach_openloop_sel;
		logic [3:0] tach_pole_divider;
		logic cycle_adjust_sel;
		logic [2:0] phase_res_exponent;
		logic [3:0] phase_res_mantissa;
	} mdc_cfg_a_t;
	// second configuration register layout, msb first
	typedef struct packed {
		logic reserved;
		logic [2:0] bemf_const_exponent;
		logic [3:0] bemf_const_mantissa;
		logic advance_timing_mode;
		logic [2:0] advance_exponent;
		logic [3:0] advance_mantissa;
	} mdc_cfg_b_t;
	// register access from the serial interface engine
	typedef struct packed {
		logic wr;
		logic rd;
		logic [7:0] addr;
		logic [15:0] wdata;
	} mdc_req_t;
	// register read answer
	typedef struct packed {
		logic ack;
		logic [15:0] rdata;
	} mdc_rsp_t;
	// motor loop status from the control core
	typedef struct packed {
		logic running;
		logic closed_loop;
		logic elec_speed;
		logic [7:0] supply;
		logic [7:0] bemf;
	} mdc_motor_t;
	// decoded settings for the control core
	typedef struct packed {
		logic dither_en;
		logic [3:0] dither_pct;
		logic half_cycle;
		logic [10:0] res_code;
		logic [10:0] bemf_code;
		logic [10:0] adv_setting;
		logic [10:0] adv_time;
	} mdc_cfg_out_t;
	// tach gating phases of one motor run
	typedef enum logic [4:0] {
		MDC_TG_IDLE = 5'b00001,
		MDC_TG_OPEN = 5'b00010,
		MDC_TG_WAIT = 5'b00100,
		MDC_TG_CLOSED = 5'b01000,
		MDC_TG_REOPEN = 5'b10000
	} mdc_tg_t;
endpackage

// ### mdc_config_regs.sv
// motor drive configuration registers, decode and tach output
`timescale 1ns/1ps
`default_nettype none
`include "mdc_defines.svh"
module mdc_config_regs
	import mdc_pkg::*;
#(
	parameter int unsigned OL_DELAY_CYC = `MDC_OL_DELAY_MS * `MDC_CLK_FREQ_KHZ
)
(
	input wire logic clk,
	input wire logic arst_n,
	input var mdc_req_t req,
	output var mdc_rsp_t rsp,
	input wire logic shadow_select,
	input wire logic [15:0] nv_cfg_a,
	input wire logic [15:0] nv_cfg_b,
	input var mdc_motor_t motor,
	output var mdc_cfg_out_t cfg_out,
	output logic tach_output
);
	typedef struct packed {
		mdc_cfg_a_t cfg_a;
		mdc_cfg_b_t cfg_b;
		mdc_rsp_t rsp;
		mdc_cfg_out_t cfg_out;
		mdc_tg_t tg;
		logic [21:0] delay_cnt;
		logic [3:0] div_cnt;
		logic speed_prev;
		logic tach;
	} mdc_state_t;

	mdc_state_t st;
	mdc_state_t next_st;
	mdc_cfg_a_t eff_a;
	mdc_cfg_b_t eff_b;
	logic tach_gate;
	logic speed_event;

	// mantissa shifted by exponent, widest case 15 << 7
	function automatic logic [10:0] mdc_shift_code(input logic [3:0] mant, input logic [2:0] expo);
		mdc_shift_code = 11'({7'h00, mant} << expo);
	endfunction

	// scale setting by (supply - bemf) / supply; bemf above supply clamps to zero
	function automatic logic [10:0] mdc_scale_adv(input logic [10:0] tset, input logic [7:0] u, input logic [7:0] e);
		logic [18:0] prod;
		prod = 19'h00000;
		if (u == 8'h00)
			mdc_scale_adv = tset;
		else if (e >= u)
			mdc_scale_adv = 11'h000;
		else
		begin
			prod = tset * (u - e);
			mdc_scale_adv = 11'(prod / {11'h000, u});
		end
	endfunction

	// settings in force: shadow registers or nonvolatile contents
	always_comb
	begin
		eff_a = shadow_select ? st.cfg_a : mdc_cfg_a_t'(nv_cfg_a);
		eff_b = shadow_select ? st.cfg_b : mdc_cfg_b_t'(nv_cfg_b & `MDC_CFG_B_WMASK);
	end

	// tach gating by loop phase and open-loop select
	always_comb
	begin
		case (eff_a.tach_openloop_sel)
			`MDC_OL_BOTH: tach_gate = motor.running;
			`MDC_OL_CLOSED_ONLY: tach_gate = (st.tg == MDC_TG_CLOSED);
			`MDC_OL_FIRST_OPEN: tach_gate = (st.tg == MDC_TG_OPEN) || (st.tg == MDC_TG_WAIT)
				|| (st.tg == MDC_TG_CLOSED);
			default: tach_gate = 1'b0; // reserved code drives nothing
		endcase
		// half-cycle counts both edges of the speed input, full-cycle only rising
		if (eff_a.cycle_adjust_sel)
			speed_event = motor.elec_speed ^ st.speed_prev;
		else
			speed_event = motor.elec_speed & ~st.speed_prev;
	end

	// next state of the whole bank
	always_comb
	begin
		next_st = st;
		next_st.rsp.ack = 1'b0;
		next_st.speed_prev = motor.elec_speed;
		// register writes; reserved bits never stored
		if (req.wr && req.addr == `MDC_ADDR_CFG_A)
			next_st.cfg_a = mdc_cfg_a_t'(req.wdata & `MDC_CFG_A_WMASK);
		if (req.wr && req.addr == `MDC_ADDR_CFG_B)
			next_st.cfg_b = mdc_cfg_b_t'(req.wdata & `MDC_CFG_B_WMASK);
		// reads answer one cycle later; unmapped reads return zero
		if (req.rd)
		begin
			next_st.rsp.ack = 1'b1;
			if (req.addr == `MDC_ADDR_CFG_A)
				next_st.rsp.rdata = 16'(eff_a);
			else if (req.addr == `MDC_ADDR_CFG_B)
				next_st.rsp.rdata = 16'(eff_b) & `MDC_CFG_B_WMASK;
			else
				next_st.rsp.rdata = 16'h0000;
		end
		// dither amount
		next_st.cfg_out.dither_en = (eff_a.spread_spectrum_sel != `MDC_SS_OFF);
		case (eff_a.spread_spectrum_sel)
			`MDC_SS_5: next_st.cfg_out.dither_pct = `MDC_DITHER_5;
			`MDC_SS_10: next_st.cfg_out.dither_pct = `MDC_DITHER_10;
			`MDC_SS_15: next_st.cfg_out.dither_pct = `MDC_DITHER_15;
			default: next_st.cfg_out.dither_pct = 4'h0;
		endcase
		next_st.cfg_out.half_cycle = eff_a.cycle_adjust_sel;
		next_st.cfg_out.res_code = mdc_shift_code(eff_a.phase_res_mantissa, eff_a.phase_res_exponent);
		next_st.cfg_out.bemf_code = mdc_shift_code(eff_b.bemf_const_mantissa, eff_b.bemf_const_exponent);
		next_st.cfg_out.adv_setting = mdc_shift_code(eff_b.advance_mantissa, eff_b.advance_exponent);
		// advance: fixed setting or scaled by remaining drive headroom
		if (eff_b.advance_timing_mode)
			next_st.cfg_out.adv_time = mdc_scale_adv(next_st.cfg_out.adv_setting, motor.supply, motor.bemf);
		else
			next_st.cfg_out.adv_time = next_st.cfg_out.adv_setting;
		// loop phase tracking; delay counts only while closed loop holds
		next_st.delay_cnt = 22'h000000;
		if (!motor.running)
			next_st.tg = MDC_TG_IDLE;
		else
		begin
			case (st.tg)
				MDC_TG_IDLE: next_st.tg = motor.closed_loop ? MDC_TG_WAIT : MDC_TG_OPEN;
				MDC_TG_OPEN: next_st.tg = motor.closed_loop ? MDC_TG_WAIT : MDC_TG_OPEN;
				MDC_TG_WAIT:
				begin
					if (!motor.closed_loop)
						next_st.tg = MDC_TG_REOPEN;
					else if (32'(st.delay_cnt) >= OL_DELAY_CYC - 1)
						next_st.tg = MDC_TG_CLOSED;
					else
						next_st.delay_cnt = st.delay_cnt + 22'h000001;
				end
				MDC_TG_CLOSED: next_st.tg = motor.closed_loop ? MDC_TG_CLOSED : MDC_TG_REOPEN;
				MDC_TG_REOPEN: next_st.tg = motor.closed_loop ? MDC_TG_WAIT : MDC_TG_REOPEN;
				default: next_st.tg = MDC_TG_IDLE;
			endcase
		end
		// pole divider: toggle after n+1 speed events
		if (!tach_gate)
		begin
			next_st.div_cnt = 4'h0;
			next_st.tach = 1'b0;
		end
		else if (speed_event)
		begin
			if (st.div_cnt >= eff_a.tach_pole_divider)
			begin
				next_st.div_cnt = 4'h0;
				next_st.tach = ~st.tach;
			end
			else
				next_st.div_cnt = st.div_cnt + 4'h1;
		end
	end

	// single state register; reset puts both config words at zero
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			st <= '0;
			st.tg <= MDC_TG_IDLE;
		end
		else
			st <= next_st;
	end

	assign rsp = st.rsp;
	assign cfg_out = st.cfg_out;
	assign tach_output = st.tach;

	default clocking mdc_cb @(posedge clk);
	endclocking
	default disable iff (!arst_n);

	sequence mdc_wr_b_seq;
		req.wr && req.addr == `MDC_ADDR_CFG_B;
	endsequence
	// read of the second register with no write in the same cycle
	sequence mdc_rd_b_seq;
		req.rd && req.addr == `MDC_ADDR_CFG_B && !req.wr;
	endsequence

	AST_DITHER_15: assert property (eff_a.spread_spectrum_sel == `MDC_SS_15 |=> cfg_out.dither_pct == 4'hF)
		else $error("dither code 11 did not give 15 percent");
	AST_DITHER_OFF: assert property (eff_a.spread_spectrum_sel == `MDC_SS_OFF |=> !cfg_out.dither_en)
		else $error("dither on with code 00");
	AST_RESERVED_OL: assert property (eff_a.tach_openloop_sel == 2'h3 |=> !tach_output)
		else $error("tach driven on reserved select");
	AST_CLOSED_ONLY: assert property (eff_a.tach_openloop_sel == `MDC_OL_CLOSED_ONLY && st.tg != MDC_TG_CLOSED
		|=> !tach_output)
		else $error("tach early in closed-only mode");
	AST_DIV_BOUND: assert property (tach_gate |-> st.div_cnt <= eff_a.tach_pole_divider)
		else $error("pole divider count overran");
	AST_RES_CODE: assert property (##1 cfg_out.res_code == 11'({7'h00, $past(eff_a.phase_res_mantissa)}
		<< $past(eff_a.phase_res_exponent)))
		else $error("resistance code mismatch");
	AST_BEMF_CODE: assert property (##1 cfg_out.bemf_code == 11'({7'h00, $past(eff_b.bemf_const_mantissa)}
		<< $past(eff_b.bemf_const_exponent)))
		else $error("back-emf code mismatch");
	AST_ADV_FIXED: assert property (!eff_b.advance_timing_mode |=> cfg_out.adv_time == cfg_out.adv_setting)
		else $error("fixed advance differs from setting");
	AST_ADV_SCALED: assert property (eff_b.advance_timing_mode |=> cfg_out.adv_time <= cfg_out.adv_setting)
		else $error("scaled advance above setting");
	AST_RSVD_READ: assert property (shadow_select ##0 mdc_rd_b_seq |=> rsp.ack && !rsp.rdata[15])
		else $error("reserved bit read back set");
	AST_RSVD_STORE: assert property (mdc_wr_b_seq |=> !st.cfg_b.reserved)
		else $error("reserved bit stored on write");
	AST_SHADOW_READ: assert property (req.rd && req.addr == `MDC_ADDR_CFG_A && !shadow_select
		|=> rsp.ack && rsp.rdata == $past(nv_cfg_a))
		else $error("read did not follow nonvolatile contents");
endmodule
`default_nettype wire

// ### mdc_host_model.sv
// host model driving register writes and reads
`timescale 1ns/1ps
`default_nettype none
`include "mdc_defines.svh"
module mdc_host_model
	import mdc_pkg::*;
(
	input wire logic clk,
	output var mdc_req_t req,
	input var mdc_rsp_t rsp
);
	// bus idle from time zero
	initial req = '0;
	// ohms over the lsb weight, cut to mantissa and exponent
	function automatic logic [6:0] enc_res(input int raw);
		int e;
		e = 0;
		while (raw > 15)
		begin
			raw = raw >> 1;
			e++;
		end
		return {3'(e), 4'(raw)};
	endfunction
	// bit 15 of the second register stays clear unless a test wants it
	task automatic wr(input logic [7:0] a, input logic [15:0] d, input bit keep_rsv = 0);
		@(posedge clk);
		req.wr <= 1'b1;
		req.addr <= a;
		req.wdata <= (a == `MDC_ADDR_CFG_B && !keep_rsv) ? (d & 16'h7FFF) : d;
		@(posedge clk);
		req.wr <= 1'b0;
	endtask
	// a missing acknowledge leaves unknown data, so it cannot match
	task automatic rd(input logic [7:0] a, output logic [15:0] q);
		@(posedge clk);
		req.rd <= 1'b1;
		req.addr <= a;
		@(posedge clk);
		req.rd <= 1'b0;
		q = 'x;
		repeat (4)
		begin
			@(posedge clk);
			if (rsp.ack === 1'b1)
			begin
				q = rsp.rdata;
				break;
			end
		end
	endtask
endmodule
`default_nettype wire

// ### mdc_config_regs_tb.sv
// self-checking bench of the motor configuration bank
`timescale 1ns/1ps
`default_nettype none
`include "mdc_defines.svh"
`define CHK(g, x) begin n_checks++; if ((g) !== (x)) begin err_count++; $display("Error at %0t: got %h expected %h", $time, g, x); end end
module mdc_config_regs_tb
	import mdc_pkg::*;
;
	logic clk;
	logic arst_n;
	mdc_req_t req;
	mdc_rsp_t rsp;
	logic shadow_select;
	logic [15:0] nv_cfg_a;
	logic [15:0] nv_cfg_b;
	mdc_motor_t motor;
	mdc_cfg_out_t cfg_out;
	logic tach_output;
	logic prev_tach;
	int err_count = 0;
	int n_checks = 0;
	int tog;
	int seed = 32'hd529be62;
	logic [15:0] a;
	logic [15:0] b;
	logic [15:0] q;
	logic [7:0] s;
	logic [7:0] e;
	mdc_config_regs #(.OL_DELAY_CYC(20)) mdc_config_regs_inst (.clk(clk), .arst_n(arst_n), .req(req), .rsp(rsp),
		.shadow_select(shadow_select), .nv_cfg_a(nv_cfg_a), .nv_cfg_b(nv_cfg_b), .motor(motor),
		.cfg_out(cfg_out), .tach_output(tach_output));
	mdc_host_model host_inst (.clk(clk), .req(req), .rsp(rsp));
	// integer model of the decoded settings
	function automatic mdc_cfg_out_t model(input logic [15:0] ra, input logic [15:0] rb, input int su, input int bm);
		mdc_cfg_out_t o;
		int st;
		st = int'(rb[3:0]) << rb[6:4];
		o.dither_en = ra[15:14] != 2'h0;
		o.dither_pct = 4'(5 * ra[15:14]);
		o.half_cycle = ra[7];
		o.res_code = 11'(int'(ra[3:0]) << ra[6:4]);
		o.bemf_code = 11'(int'(rb[11:8]) << rb[14:12]);
		o.adv_setting = 11'(st);
		o.adv_time = (!rb[7] || su == 0) ? 11'(st) : ((bm >= su) ? 11'h000 : 11'(st * (su - bm) / su));
		return o;
	endfunction
	// tach transitions, restarted by each run
	always @(posedge clk)
	begin
		prev_tach <= tach_output;
		if (tach_output !== prev_tach)
			tog++;
	end
	// one tach run: 8 speed periods, two cycles per half period
	task automatic tach_run(input logic [1:0] sel, input bit cl, input bit gate, input bit adj, input logic [3:0] n);
		host_inst.wr(`MDC_ADDR_CFG_A, {2'h0, sel, n, adj, 7'h00});
		@(posedge clk);
		motor.running <= 1'b1;
		motor.closed_loop <= cl;
		repeat (cl ? 25 : 3) @(posedge clk);
		tog = 0;
		repeat (16)
		begin
			repeat (2) @(posedge clk);
			motor.elec_speed <= ~motor.elec_speed;
		end
		repeat (4) @(posedge clk);
		`CHK(tog, gate ? (adj ? 16 : 8) / (n + 1) : 0)
		motor.running <= 1'b0;
		motor.closed_loop <= 1'b0;
		repeat (3) @(posedge clk);
	endtask
	task automatic final_report();
		$display("checks %0d errors %0d", n_checks, err_count);
		if (err_count == 0 && n_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	// 10 MHz clock
	initial
	begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	// watchdog well beyond the expected run
	initial
	begin
		repeat (5000) @(posedge clk);
		err_count++;
		final_report();
	end
	initial
	begin
		arst_n = 1'b0;
		shadow_select = 1'b1;
		nv_cfg_a = '0;
		nv_cfg_b = '0;
		motor = '0;
		repeat (3) @(posedge clk);
		arst_n <= 1'b1;
		`CHK(cfg_out, mdc_cfg_out_t'(0))
		host_inst.rd(`MDC_ADDR_CFG_A, q);
		`CHK(q, `MDC_CFG_A_RESET)
		host_inst.rd(`MDC_ADDR_CFG_B, q);
		`CHK(q, `MDC_CFG_B_RESET)
		// random settings, with encoded resistance and reserved bit writes
		for (int i = 0; i < 12; i++)
		begin
			s = 8'($random(seed));
			e = 8'($random(seed));
			a = 16'($random(seed));
			a[6:0] = host_inst.enc_res($random(seed) & 32'h7FF);
			b = 16'($random(seed));
			@(posedge clk);
			motor.supply <= s;
			motor.bemf <= e;
			host_inst.wr(`MDC_ADDR_CFG_A, a);
			host_inst.wr(`MDC_ADDR_CFG_B, b, i[0]);
			host_inst.rd(`MDC_ADDR_CFG_A, q);
			`CHK(q, a)
			host_inst.rd(`MDC_ADDR_CFG_B, q);
			`CHK(q, b & 16'h7FFF)
			`CHK(cfg_out, model(a, b & 16'h7FFF, s, e))
		end
		host_inst.rd(8'h92, q);
		`CHK(q, 16'h0000)
		// nonvolatile contents in use when shadow is off
		@(posedge clk);
		shadow_select <= 1'b0;
		nv_cfg_a <= 16'($random(seed));
		nv_cfg_b <= 16'($random(seed));
		host_inst.rd(`MDC_ADDR_CFG_B, q);
		`CHK(q, nv_cfg_b & 16'h7FFF)
		host_inst.rd(`MDC_ADDR_CFG_A, q);
		`CHK(q, nv_cfg_a)
		`CHK(cfg_out, model(nv_cfg_a, nv_cfg_b & 16'h7FFF, s, e))
		@(posedge clk);
		shadow_select <= 1'b1;
		// tach gating codes and dividers
		tach_run(2'h0, 1'b0, 1'b1, 1'b0, 4'h0);
		tach_run(2'h1, 1'b0, 1'b0, 1'b1, 4'h1);
		tach_run(2'h1, 1'b1, 1'b1, 1'b0, 4'h2);
		tach_run(2'h2, 1'b0, 1'b1, 1'b1, 4'h3);
		tach_run(2'h3, 1'b0, 1'b0, 1'b0, 4'hF);
		final_report();
	end
endmodule
`default_nettype wire
